// [logic/rfc_cal_bank.sv]
// rf front-end bias, power select and synthesizer calibration register bank
`timescale 1ns/100ps
`include "rfc_defines.svh"
module rfc_cal_bank #(
    parameter int SETTLE_CYC = `RFC_SETTLE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [1:0] low_noise_amp_bias_o,
    output logic [1:0] amp_to_mixer_bias_o,
    output logic [1:0] rx_lo_buffer_bias_o,
    output logic [1:0] mixer_bias_o,
    output logic [1:0] tx_lo_buffer_bias_o,
    output logic [1:0] cal_config_o,
    output logic [3:0] charge_pump_current_o,
    output logic osc_core_high_select_o,
    output logic [4:0] osc_current_o,
    output logic cal_busy_o,
    output logic cal_osc_req_o,
    output logic cal_cp_req_o,
    input wire logic meas_valid_i,
    input wire logic [4:0] osc_meas_i,
    input wire logic [3:0] cp_meas_i,
    input wire logic tx_active_i,
    input wire logic ook_mode_i,
    input wire logic tx_symbol_i,
    input wire logic tx_step_i,
    output logic [2:0] power_table_index_o,
    output logic tx_level_reached_o,
    output logic tx_idle_o
);
    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

    rfc_pkg::rfc_bank_t bank_reg;
    rfc_pkg::rfc_bank_t bank_next;
    logic wr_rx;
    logic wr_tx;
    logic wr_cp;
    logic wr_osc;
    logic wr_ctrl;
    logic start_req;
    logic [7:0] ctrl_view;

    rfc_pwr_if pwr_link ();

    rfc_power_seq u_seq (
        .ref_clk_i (ref_clk_i),
        .rst_i (rst_i),
        .pwr (pwr_link.seq)
    );

    assign pwr_link.power_index = bank_reg.pwr_idx;
    assign pwr_link.ook_mode = ook_mode_i;
    assign pwr_link.tx_active = tx_active_i;
    assign pwr_link.tx_symbol = tx_symbol_i;
    assign pwr_link.step = tx_step_i;

    // address decode; unmapped writes fall through untouched
    always_comb begin
        wr_rx = reg_wr_i && (reg_addr_i == `RFC_OFS_RX_BIAS);
        wr_tx = reg_wr_i && (reg_addr_i == `RFC_OFS_TX_PWR);
        wr_cp = reg_wr_i && (reg_addr_i == `RFC_OFS_CP);
        wr_osc = reg_wr_i && (reg_addr_i == `RFC_OFS_OSC);
        wr_ctrl = reg_wr_i && (reg_addr_i == `RFC_OFS_CAL_CTRL);
        start_req = wr_ctrl && reg_wdata_i[`RFC_START_BIT];
    end

    // calibration status view: done, busy, skip flag, live table index
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`RFC_DONE_BIT] = bank_reg.cal_done;
        ctrl_view[`RFC_BUSY_BIT] = (bank_reg.cal_st != rfc_pkg::CAL_IDLE);
        ctrl_view[`RFC_SKIP_BIT] = bank_reg.cp_skipped;
        ctrl_view[`RFC_IDX_LSB +: 3] = pwr_link.table_index;
    end

    always_comb begin
        bank_next = bank_reg;

        // software writes; only defined fields are stored
        if (wr_rx) begin
            bank_next.rx_bias = reg_wdata_i; // RULE_01
        end
        if (wr_tx) begin
            bank_next.tx_lo = reg_wdata_i[`RFC_TXLO_LSB +: 2]; // RULE_02 RULE_12
            bank_next.pwr_idx = reg_wdata_i[`RFC_PWR_LSB +: 3]; // RULE_03 RULE_12
        end
        if (wr_cp) begin
            bank_next.cal_cfg = reg_wdata_i[`RFC_CFG_LSB +: 2];
            bank_next.cp_en = reg_wdata_i[`RFC_CPEN_LSB +: 2]; // RULE_07
            bank_next.cp_code = reg_wdata_i[`RFC_CPCODE_LSB +: 4]; // RULE_08 RULE_09
        end
        if (wr_osc) begin
            bank_next.osc_hi = reg_wdata_i[`RFC_OSCHI_BIT]; // RULE_10 RULE_12
            bank_next.osc_code = reg_wdata_i[`RFC_OSCCODE_LSB +: 5]; // RULE_11 RULE_09
        end

        // done flag: writing one clears it, a new completion wins
        if (wr_ctrl && reg_wdata_i[`RFC_DONE_BIT]) begin
            bank_next.cal_done = 1'b0;
        end

        // calibration sequencer; a start while busy is ignored
        case (bank_reg.cal_st)
            rfc_pkg::CAL_IDLE: begin
                if (start_req) begin
                    bank_next.cal_st = rfc_pkg::CAL_SETTLE;
                    bank_next.settle = 8'h00;
                    bank_next.cp_skipped = 1'b0;
                end
            end
            rfc_pkg::CAL_SETTLE: begin
                // let the chosen core and config settle before measuring
                if (bank_reg.settle >= SETTLE_LAST) begin
                    bank_next.cal_st = rfc_pkg::CAL_OSC;
                end else begin
                    bank_next.settle = bank_reg.settle + 8'h01;
                end
            end
            rfc_pkg::CAL_OSC: begin
                if (meas_valid_i) begin
                    bank_next.osc_code = osc_meas_i; // RULE_13 RULE_11
                    if (bank_reg.cp_en == 2'h0) begin
                        bank_next.cal_st = rfc_pkg::CAL_IDLE; // RULE_07
                        bank_next.cp_skipped = 1'b1; // RULE_07
                        bank_next.cal_done = 1'b1;
                    end else begin
                        bank_next.cal_st = rfc_pkg::CAL_CP;
                    end
                end
            end
            rfc_pkg::CAL_CP: begin
                if (meas_valid_i) begin
                    bank_next.cp_code = cp_meas_i; // RULE_13 RULE_08
                    bank_next.cal_st = rfc_pkg::CAL_IDLE;
                    bank_next.cal_done = 1'b1;
                end
            end
            default: begin
                bank_next.cal_st = rfc_pkg::CAL_IDLE;
            end
        endcase

        // read data stand for the one cycle after the strobe
        bank_next.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `RFC_OFS_RX_BIAS: begin
                    bank_next.rdata = bank_reg.rx_bias;
                end
                `RFC_OFS_TX_PWR: begin
                    bank_next.rdata[`RFC_TXLO_LSB +: 2] = bank_reg.tx_lo; // RULE_12
                    bank_next.rdata[`RFC_PWR_LSB +: 3] = bank_reg.pwr_idx;
                end
                `RFC_OFS_CP: begin
                    bank_next.rdata[`RFC_CFG_LSB +: 2] = bank_reg.cal_cfg;
                    bank_next.rdata[`RFC_CPEN_LSB +: 2] = bank_reg.cp_en;
                    bank_next.rdata[`RFC_CPCODE_LSB +: 4] = bank_reg.cp_code; // RULE_09
                end
                `RFC_OFS_OSC: begin
                    bank_next.rdata[`RFC_OSCHI_BIT] = bank_reg.osc_hi; // RULE_12
                    bank_next.rdata[`RFC_OSCCODE_LSB +: 5] = bank_reg.osc_code; // RULE_09
                end
                `RFC_OFS_CAL_CTRL: begin
                    bank_next.rdata = ctrl_view;
                end
                default: begin
                    bank_next.rdata = 8'h00; // RULE_12
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_reg.rx_bias <= `RFC_RST_RX_BIAS; // RULE_01
            bank_reg.tx_lo <= `RFC_RST_TX_LO; // RULE_02
            bank_reg.pwr_idx <= `RFC_RST_PWR_IDX; // RULE_03
            bank_reg.cal_cfg <= `RFC_RST_CAL_CFG;
            bank_reg.cp_en <= `RFC_RST_CP_EN; // RULE_07
            bank_reg.cp_code <= `RFC_RST_CP_CODE; // RULE_08
            bank_reg.osc_hi <= `RFC_RST_OSC_HI; // RULE_10
            bank_reg.osc_code <= `RFC_RST_OSC_CODE; // RULE_11
            bank_reg.cal_st <= rfc_pkg::CAL_IDLE;
            bank_reg.settle <= 8'h00;
            bank_reg.cal_done <= 1'b0;
            bank_reg.cp_skipped <= 1'b0;
            bank_reg.rdata <= 8'h00;
        end else begin
            bank_reg <= bank_next;
        end
    end

    assign reg_rdata_o = bank_reg.rdata;

    // analog settings follow the stored fields, written or calibrated
    assign low_noise_amp_bias_o = bank_reg.rx_bias[`RFC_LNA_LSB +: 2]; // RULE_01
    assign amp_to_mixer_bias_o = bank_reg.rx_bias[`RFC_A2M_LSB +: 2]; // RULE_01
    assign rx_lo_buffer_bias_o = bank_reg.rx_bias[`RFC_RXLO_LSB +: 2]; // RULE_01
    assign mixer_bias_o = bank_reg.rx_bias[`RFC_MIX_LSB +: 2]; // RULE_01
    assign tx_lo_buffer_bias_o = bank_reg.tx_lo; // RULE_02
    assign cal_config_o = bank_reg.cal_cfg;
    assign charge_pump_current_o = bank_reg.cp_code; // RULE_08 RULE_09
    assign osc_core_high_select_o = bank_reg.osc_hi; // RULE_10
    assign osc_current_o = bank_reg.osc_code; // RULE_11 RULE_09

    assign cal_busy_o = (bank_reg.cal_st != rfc_pkg::CAL_IDLE);
    assign cal_osc_req_o = (bank_reg.cal_st == rfc_pkg::CAL_OSC);
    assign cal_cp_req_o = (bank_reg.cal_st == rfc_pkg::CAL_CP);

    assign power_table_index_o = pwr_link.table_index; // RULE_05
    assign tx_level_reached_o = pwr_link.level_reached;
    assign tx_idle_o = pwr_link.idle;
endmodule

// [logic/rfc_defines.svh]
// offsets, field positions, reset values and timing counts of the rf front-end bank
// Contract
// RULE_01 - rx bias fields, three reset 01, mixer 10
// RULE_02 - tx lo buffer field bits 5:4, reset 1
// RULE_03 - power index bits 2:0 selects table entry
// RULE_04 - keyed: one uses index, zero uses entry 0
// RULE_05 - ramps and shaping step entries zero to index
// RULE_06 - software loads cal config before calibration
// RULE_07 - charge pump stage skipped when enable zero
// RULE_08 - charge pump code bits 3:0, reset 1001
// RULE_09 - results readable, writable, written values used
// RULE_10 - bit 5 selects high or low oscillator
// RULE_11 - oscillator current result, write overrides it
// RULE_12 - unused bits read zero, writes ignored
// RULE_13 - calibration end overwrites result fields
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH

`define RFC_OFS_RX_BIAS 8'h21
`define RFC_OFS_TX_PWR 8'h22
`define RFC_OFS_CP 8'h23
`define RFC_OFS_OSC 8'h24
`define RFC_OFS_CAL_CTRL 8'h3E

`define RFC_LNA_LSB 6
`define RFC_A2M_LSB 4
`define RFC_RXLO_LSB 2
`define RFC_MIX_LSB 0
`define RFC_TXLO_LSB 4
`define RFC_PWR_LSB 0
`define RFC_CFG_LSB 6
`define RFC_CPEN_LSB 4
`define RFC_CPCODE_LSB 0
`define RFC_OSCHI_BIT 5
`define RFC_OSCCODE_LSB 0
`define RFC_START_BIT 0
`define RFC_DONE_BIT 1
`define RFC_BUSY_BIT 2
`define RFC_SKIP_BIT 3
`define RFC_IDX_LSB 4

`define RFC_RST_RX_BIAS 8'h56
`define RFC_RST_TX_LO 2'h1
`define RFC_RST_PWR_IDX 3'h0
`define RFC_RST_CAL_CFG 2'h2
`define RFC_RST_CP_EN 2'h2
`define RFC_RST_CP_CODE 4'h9
`define RFC_RST_OSC_HI 1'h0
`define RFC_RST_OSC_CODE 5'h0A

`define RFC_CLK_MHZ 10
`define RFC_SETTLE_NS 1000
`define RFC_SETTLE_CYC ((`RFC_SETTLE_NS * `RFC_CLK_MHZ + 999) / 1000)

`endif

// [logic/rfc_pkg.sv]
// types shared by the rf front-end bank modules
package rfc_pkg;
    typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_OSC, CAL_CP} rfc_cal_state_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DOWN} rfc_seq_state_t;

    typedef struct packed {
        logic [7:0] rx_bias;
        logic [1:0] tx_lo;
        logic [2:0] pwr_idx;
        logic [1:0] cal_cfg;
        logic [1:0] cp_en;
        logic [3:0] cp_code;
        logic osc_hi;
        logic [4:0] osc_code;
        rfc_cal_state_t cal_st;
        logic [7:0] settle;
        logic cal_done;
        logic cp_skipped;
        logic [7:0] rdata;
    } rfc_bank_t;

    typedef struct packed {
        rfc_seq_state_t st;
        logic [2:0] idx;
    } rfc_seq_t;
endpackage

// [logic/rfc_pwr_if.sv]
// power sequencer link between the register bank and the ramp sequencer
`timescale 1ns/100ps
interface rfc_pwr_if;
    logic [2:0] power_index;
    logic ook_mode;
    logic tx_active;
    logic tx_symbol;
    logic step;
    logic [2:0] table_index;
    logic level_reached;
    logic idle;

    modport ctrl (
        output power_index, ook_mode, tx_active, tx_symbol, step,
        input table_index, level_reached, idle
    );
    modport seq (
        input power_index, ook_mode, tx_active, tx_symbol, step,
        output table_index, level_reached, idle
    );
endinterface

// [logic/rfc_power_seq.sv]
// power table index sequencer: ramp up, keyed levels, ramp down
`timescale 1ns/100ps
module rfc_power_seq (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    rfc_pwr_if.seq pwr
);
    rfc_pkg::rfc_seq_t state_reg;
    rfc_pkg::rfc_seq_t state_next;
    logic [2:0] target;

    // level to head for; keyed zero symbols use entry zero
    always_comb begin
        target = 3'h0;
        if (state_reg.st == rfc_pkg::SEQ_RUN) begin
            if (pwr.ook_mode && !pwr.tx_symbol) begin
                target = 3'h0; // RULE_04
            end else begin
                target = pwr.power_index; // RULE_03 RULE_04
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        // one table entry per step, never jumping levels
        if (pwr.step) begin
            if (state_reg.idx < target) begin
                state_next.idx = state_reg.idx + 3'h1; // RULE_05
            end else if (state_reg.idx > target) begin
                state_next.idx = state_reg.idx - 3'h1; // RULE_05
            end
        end
        case (state_reg.st)
            rfc_pkg::SEQ_IDLE: begin
                if (pwr.tx_active) begin
                    state_next.st = rfc_pkg::SEQ_RUN;
                end
            end
            rfc_pkg::SEQ_RUN: begin
                if (!pwr.tx_active) begin
                    state_next.st = rfc_pkg::SEQ_DOWN;
                end
            end
            rfc_pkg::SEQ_DOWN: begin
                if (pwr.tx_active) begin
                    state_next.st = rfc_pkg::SEQ_RUN;
                end else if (state_next.idx == 3'h0) begin
                    state_next.st = rfc_pkg::SEQ_IDLE;
                end
            end
            default: begin
                state_next.st = rfc_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '{st: rfc_pkg::SEQ_IDLE, idx: 3'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pwr.table_index = state_reg.idx;
    assign pwr.level_reached = (state_reg.st == rfc_pkg::SEQ_RUN) && (state_reg.idx == target);
    assign pwr.idle = (state_reg.st == rfc_pkg::SEQ_IDLE);
endmodule

// [tb/rfc_cal_bank_checker.sv]
// port-level checks on the rf front-end register bank
`timescale 1ns/100ps
module rfc_cal_bank_checker #(
    parameter int SETTLE_CYC = 10
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [1:0] low_noise_amp_bias_o,
    input wire logic [1:0] amp_to_mixer_bias_o,
    input wire logic [1:0] rx_lo_buffer_bias_o,
    input wire logic [1:0] mixer_bias_o,
    input wire logic [3:0] charge_pump_current_o,
    input wire logic osc_core_high_select_o,
    input wire logic [4:0] osc_current_o,
    input wire logic cal_busy_o,
    input wire logic cal_osc_req_o,
    input wire logic cal_cp_req_o,
    input wire logic meas_valid_i,
    input wire logic [4:0] osc_meas_i,
    input wire logic [3:0] cp_meas_i,
    input wire logic tx_step_i,
    input wire logic [2:0] power_table_index_o
);
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] wd_q;
    always_ff @(posedge ref_clk_i) wd_q <= reg_wdata_i;
    sequence cal_go_s;
        reg_wr_i && reg_addr_i == 8'h3E && reg_wdata_i[0] && !cal_busy_o;
    endsequence
    sequence settle_s;
        cal_busy_o && !cal_osc_req_o ##[1:40] cal_osc_req_o;
    endsequence
    AST_RX_READ: assert property (reg_rd_i && reg_addr_i == 8'h21 |=>
        reg_rdata_o == {low_noise_amp_bias_o, amp_to_mixer_bias_o, rx_lo_buffer_bias_o,
        mixer_bias_o}) else $error("rx bias read mismatch");
    AST_OSC_READ: assert property (reg_rd_i && reg_addr_i == 8'h24 && !meas_valid_i |=>
        reg_rdata_o == {2'h0, osc_core_high_select_o, osc_current_o})
        else $error("oscillator read mismatch");
    AST_WR_CP: assert property (reg_wr_i && reg_addr_i == 8'h23 && !meas_valid_i |=>
        charge_pump_current_o == wd_q[3:0]) else $error("charge pump write not applied");
    AST_OSC_CAP: assert property (cal_osc_req_o && meas_valid_i |=>
        osc_current_o == $past(osc_meas_i)) else $error("oscillator result not captured");
    AST_CP_CAP: assert property (cal_cp_req_o && meas_valid_i |=>
        charge_pump_current_o == $past(cp_meas_i)) else $error("charge pump result not captured");
    AST_CAL_START: assert property (cal_go_s |=> settle_s)
        else $error("calibration start sequence wrong");
    AST_STEP_HOLD: assert property (!tx_step_i |=> $stable(power_table_index_o))
        else $error("table index moved without a step");
    AST_STEP_ONE: assert property (tx_step_i |=>
        3'(power_table_index_o - $past(power_table_index_o)) inside {3'h0, 3'h1, 3'h7})
        else $error("table index jumped");
endmodule
bind rfc_cal_bank rfc_cal_bank_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .low_noise_amp_bias_o(low_noise_amp_bias_o), .amp_to_mixer_bias_o(amp_to_mixer_bias_o),
    .rx_lo_buffer_bias_o(rx_lo_buffer_bias_o), .mixer_bias_o(mixer_bias_o),
    .charge_pump_current_o(charge_pump_current_o), .osc_current_o(osc_current_o),
    .osc_core_high_select_o(osc_core_high_select_o), .cal_busy_o(cal_busy_o),
    .cal_osc_req_o(cal_osc_req_o), .cal_cp_req_o(cal_cp_req_o), .meas_valid_i(meas_valid_i),
    .osc_meas_i(osc_meas_i), .cp_meas_i(cp_meas_i), .tx_step_i(tx_step_i),
    .power_table_index_o(power_table_index_o));

// [tb/rfc_cal_bank_bench.sv]
// self-checking bench for the rf front-end register bank
`timescale 1ns/100ps
module rfc_cal_bank_bench;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, mv = 1'b0, txa = 1'b0, ook = 1'b0, sym = 1'b0, step = 1'b0;
    logic [4:0] om = 5'h00;
    logic [3:0] cm = 4'h0;
    logic [7:0] rdata;
    logic [1:0] lna, a2m, rxlo, mix, txlo, cfg;
    logic [3:0] cpc;
    logic [4:0] oscc;
    logic oshi, busy, oreq, creq, lvl, idle;
    logic [2:0] idx;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;

    rfc_cal_bank #(.SETTLE_CYC(2)) i_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .low_noise_amp_bias_o(lna),
        .amp_to_mixer_bias_o(a2m), .rx_lo_buffer_bias_o(rxlo), .mixer_bias_o(mix),
        .tx_lo_buffer_bias_o(txlo), .cal_config_o(cfg), .charge_pump_current_o(cpc),
        .osc_core_high_select_o(oshi), .osc_current_o(oscc), .cal_busy_o(busy),
        .cal_osc_req_o(oreq), .cal_cp_req_o(creq), .meas_valid_i(mv), .osc_meas_i(om),
        .cp_meas_i(cm), .tx_active_i(txa), .ook_mode_i(ook), .tx_symbol_i(sym),
        .tx_step_i(step), .power_table_index_o(idx), .tx_level_reached_o(lvl),
        .tx_idle_o(idle));

    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        @(negedge ref_clk_i);
        chk($sformatf("register %h", a), exp, rdata);
    endtask

    task automatic meas(input logic [4:0] o, input logic [3:0] c);
        @(posedge ref_clk_i);
        mv <= 1'b1;
        om <= o;
        cm <= c;
        @(posedge ref_clk_i);
        mv <= 1'b0;
    endtask

    task automatic step_chk(input logic [2:0] exp);
        @(posedge ref_clk_i);
        step <= 1'b1;
        @(posedge ref_clk_i);
        step <= 1'b0;
        @(negedge ref_clk_i);
        chk("table index", {5'h00, exp}, {5'h00, idx});
    endtask

    task automatic t_reset;
        rd_chk(8'h21, 8'h56);
        rd_chk(8'h22, 8'h10);
        rd_chk(8'h23, 8'hA9);
        rd_chk(8'h24, 8'h0A);
        rd_chk(8'h30, 8'h00);
        chk("cal config", 8'h02, {6'h00, cfg});
    endtask

    task automatic t_rw;
        wr_reg(8'h21, 8'hB4);
        wr_reg(8'h22, 8'hFF);
        wr_reg(8'h24, 8'hFF);
        wr_reg(8'h20, 8'hFF);
        rd_chk(8'h21, 8'hB4);
        chk("rx bias", 8'hB4, {lna, a2m, rxlo, mix});
        rd_chk(8'h22, 8'h37);
        chk("tx lo", 8'h03, {6'h00, txlo});
        rd_chk(8'h24, 8'h3F);
        wr_reg(8'h24, 8'h15);
        rd_chk(8'h24, 8'h15);
        chk("osc", 8'h15, {2'h0, oshi, oscc});
    endtask

    task automatic t_cal(input logic [1:0] en, input logic [4:0] o, input logic [3:0] c);
        wr_reg(8'h23, {2'h1, en, 4'h5});
        wr_reg(8'h3E, 8'h01);
        for (int i = 0; i < 60 && oreq !== 1'b1; i++) @(negedge ref_clk_i);
        meas(o, 4'h0);
        if (en != 2'h0) begin
            for (int i = 0; i < 60 && creq !== 1'b1; i++) @(negedge ref_clk_i);
            meas(5'h00, c);
        end
        repeat (2) @(negedge ref_clk_i);
        chk("busy", 8'h00, {7'h00, busy});
        chk("cal config", 8'h01, {6'h00, cfg});
        chk("osc result", {3'h0, o}, {3'h0, oscc});
        chk("cp result", {4'h0, (en == 2'h0) ? 4'h5 : c}, {4'h0, cpc});
        rd_chk(8'h3E, {4'h0, (en == 2'h0), 3'h2});
        wr_reg(8'h3E, 8'h02);
        rd_chk(8'h3E, {4'h0, (en == 2'h0), 3'h0});
        wr_reg(8'h23, 8'hA7);
        @(negedge ref_clk_i);
        chk("cp restore", 8'h07, {4'h0, cpc});
    endtask

    task automatic t_power;
        wr_reg(8'h22, 8'h13);
        txa <= 1'b1;
        step_chk(3'h1);
        step_chk(3'h2);
        step_chk(3'h3);
        step_chk(3'h3);
        chk("level reached", 8'h01, {7'h00, lvl});
        rd_chk(8'h3E, 8'h38);
        @(posedge ref_clk_i);
        ook <= 1'b1;
        step_chk(3'h2);
        step_chk(3'h1);
        @(posedge ref_clk_i);
        sym <= 1'b1;
        step_chk(3'h2);
        @(posedge ref_clk_i);
        txa <= 1'b0;
        step_chk(3'h1);
        step_chk(3'h0);
        step_chk(3'h0);
        @(negedge ref_clk_i);
        chk("idle", 8'h01, {7'h00, idle});
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_rw();
        t_cal(2'h2, 5'h11, 4'hC);
        t_cal(2'h0, 5'h07, 4'h3);
        t_power();
        final_report();
    end
endmodule
